// ### sdc_pkg.sv
package sdc_pkg;
   // ****************************************************
   // APB register map
   // ****************************************************
   localparam logic [7:0] SDC_CTRL_OFS = 8'h00;
   localparam logic [7:0] SDC_STAT_OFS = 8'h04;
   localparam logic [7:0] SDC_CLR_OFS = 8'h08;
   localparam logic [7:0] SDC_OPC_OFS = 8'h0c;
   localparam int SDC_CTRL_EN = 0;
   localparam logic SDC_CTRL_EN_RST = 1'b1;
   localparam int SDC_ST_INVALID = 0;
   localparam int SDC_ST_REJECT = 1;
   localparam int SDC_ST_SCKMODE = 2;
   localparam int SDC_ST_BUSYN = 3;
   localparam int SDC_ST_DIR = 4;
   localparam int SDC_ST_RUNNING = 5;

   // ****************************************************
   // Serial opcodes
   // ****************************************************
   localparam logic [7:0] SDC_OP_NOP = 8'h00;
   localparam logic [2:0] SDC_OP_WRITE_HI = 3'h0;
   localparam logic [2:0] SDC_OP_READ_HI = 3'h1;
   localparam logic [6:0] SDC_OP_RUN = 7'h28;
   localparam logic [6:0] SDC_OP_STEP = 7'h2c;
   localparam logic [6:0] SDC_OP_MOVE = 7'h20;
   localparam logic [7:0] SDC_OP_ABSOLUTE_POSITION_COMMAND = 8'h60;
   localparam logic [1:0] SDC_ARG_BYTES = 2'd3;

   // ****************************************************
   // Parameter registers behind the serial link
   // ****************************************************
   localparam logic [4:0] SDC_RA_POS = 5'h01;
   localparam logic [4:0] SDC_RA_SPEED = 5'h04;
   localparam logic [4:0] SDC_RA_MAXSPD = 5'h07;
   localparam logic [4:0] SDC_RA_MINSPD = 5'h08;
   localparam logic [1:0] SDC_REG_BYTES = 2'd3;
   localparam logic [19:0] SDC_MAXSPD_RST = 20'h10000;
   localparam logic [19:0] SDC_MINSPD_RST = 20'h00000;

   typedef enum {SDC_IDLE, SDC_ARGS} sdc_state_t;
   typedef enum {SDC_K_WRITE, SDC_K_RUN, SDC_K_MOVE, SDC_K_ABSOLUTE_POSITION_COMMAND} sdc_kind_t;
endpackage

// ### sdc_decoder.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [RULE1] Write opcode has top three bits zero; low five bits address the register.
// [RULE2] Write value follows, MSB first, as many bytes as the register is long.
// [RULE3] Write to a read-only register is dropped; invalid flag at opcode end.
// [RULE4] Conditional write outside its condition dropped; rejected flag at last byte.
// [RULE5] Write to an unknown address is dropped; invalid flag at opcode end.
// [RULE6] Read opcode 001 plus address returns register MSB first, full length.
// [RULE7] Read value is frozen when the opcode is decoded.
// [RULE8] Every register can be read at any time in any mode.
// [RULE9] Read of an unknown address is dropped; invalid flag at opcode end.
// [RULE10] Constant speed opcode 0101000x; bit 0 one is forward, zero reverse.
// [RULE11] Speed is 0.28 fixed point in three bytes; top nibble ignored.
// [RULE12] Target speed is clamped between lower and upper speed limits.
// [RULE13] Constant speed accepted anytime, runs at once; busy low until reached.
// [RULE14] External step command enters step-clock mode; motor then reads stopped.
// [RULE15] Motion commands leave step-clock mode; repeat step command only sets direction.
// [RULE16] Bridge fault events do not leave step-clock mode.
// [RULE17] External step leaves busy alone; refused with rejected flag while running.
// [RULE18] Relative step moves the count in direction of bit 0, current step units.
// [RULE19] Relative step holds busy low until done; refused while running.
// [RULE20] Absolute position goes to the target by shortest path, current step units.
// [RULE21] Absolute position holds busy low; refused with rejected flag while busy.
// [RULE22] Every received byte answers zero except register read responses.
// [RULE23] A new read aborts an unfinished response and loads its own.
// [RULE24] Unknown opcode byte is ignored and raises the invalid flag.
// [RULE25] Speed, step and position commands take three argument bytes, MSB first.
module sdc_decoder
   import sdc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link from host
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Motion engine side
   input wire logic motor_running,
   input wire logic motion_done,
   input wire logic [19:0] cur_speed,
   input wire logic [21:0] cur_pos,
   output logic cmd_run,
   output logic cmd_move,
   output logic cmd_absolute_position_command,
   output logic pos_load,
   output logic cmd_dir,
   output logic [21:0] cmd_arg,
   output logic step_clock_mode_flag,
   output logic busy_n
);

   // ****************************************************
   // Link input synchronisers
   // ****************************************************
   logic [2:0] sclk_s, cs_s, mosi_s;
   logic sclk_f, cs_f, mosi_f, sclk_nx, sclk_rise, sclk_fall;

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sclk_s <= 3'h7;
         cs_s <= 3'h7;
         mosi_s <= 3'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], spi_sclk};
         cs_s <= {cs_s[1:0], spi_cs_n};
         mosi_s <= {mosi_s[1:0], spi_mosi};
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sclk_f <= 1'b1;
         cs_f <= 1'b1;
         mosi_f <= 1'b0;
      end else begin
         sclk_f <= sclk_nx;
         if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
         if (mosi_s[1] == mosi_s[2]) mosi_f <= mosi_s[2];
      end
   end

   assign sclk_nx = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_f;
   assign sclk_rise = ~sclk_f & sclk_nx;
   assign sclk_fall = sclk_f & ~sclk_nx;

   // ****************************************************
   // APB registers
   // ****************************************************
   logic ctrl_en_reg, invalid_reg, reject_reg;
   logic [7:0] last_op_reg;
   logic apb_wr, apb_ok;
   logic [31:0] rd_next;

   assign apb_wr = psel & penable & pwrite;
   assign apb_ok = paddr == SDC_CTRL_OFS || paddr == SDC_STAT_OFS ||
                   paddr == SDC_CLR_OFS || paddr == SDC_OPC_OFS;
   // Zero wait states; unmapped offsets answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~apb_ok;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) ctrl_en_reg <= SDC_CTRL_EN_RST;
      else if (apb_wr && paddr == SDC_CTRL_OFS) ctrl_en_reg <= pwdata[SDC_CTRL_EN];
   end

   // ****************************************************
   // Bit and byte engine
   // ****************************************************
   logic active, byte_done;
   logic [2:0] bit_cnt;
   logic [6:0] rx_sh;
   logic [7:0] rx_byte, tx_sh;

   // Disabled link ignores the host entirely and leaves miso undriven
   assign active = ~cs_f & ctrl_en_reg;
   assign byte_done = active & sclk_rise & (bit_cnt == 3'h7);
   assign rx_byte = {rx_sh, mosi_f};

   // Sample on rising clock; a frame break restarts the byte
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         bit_cnt <= 3'h0;
         rx_sh <= 7'h00;
      end else if (!active) begin
         bit_cnt <= 3'h0;
      end else if (sclk_rise) begin
         rx_sh <= rx_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   assign spi_miso = tx_sh[7];
   assign spi_miso_oe = active;

   // ****************************************************
   // Register decode helpers
   // ****************************************************
   function automatic logic [1:0] reg_len(input logic [4:0] a);
      case (a)
         SDC_RA_POS, SDC_RA_SPEED, SDC_RA_MAXSPD, SDC_RA_MINSPD: reg_len = SDC_REG_BYTES;
         default: reg_len = 2'd0;
      endcase
   endfunction

   logic [19:0] max_spd_reg, min_spd_reg;
   logic [23:0] snap;

   // Live value for reads; no mode gates it [RULE8]
   always_comb begin
      case (rx_byte[4:0])
         SDC_RA_POS: snap = {2'h0, cur_pos};
         SDC_RA_SPEED: snap = {4'h0, cur_speed};
         SDC_RA_MAXSPD: snap = {4'h0, max_spd_reg};
         SDC_RA_MINSPD: snap = {4'h0, min_spd_reg};
         default: snap = 24'h000000;
      endcase
   end

   // ****************************************************
   // Command decode
   // ****************************************************
   sdc_state_t state;
   sdc_kind_t kind, new_kind;
   logic [1:0] arg_left;
   logic [4:0] addr_reg;
   logic [15:0] arg_sh;
   logic [23:0] full_arg;
   logic busy_n_reg, sck_mode_reg, dir_reg, running_rep;
   logic ev_invalid, ev_reject, start_args, last_arg;
   logic go_read, go_step, go_write, go_run, go_move, go_absolute_position_command;

   // Motor counts as stopped in step-clock mode [RULE14]
   assign running_rep = motor_running & ~sck_mode_reg;
   assign full_arg = {arg_sh, rx_byte};
   assign last_arg = byte_done && state == SDC_ARGS && arg_left == 2'd1;

   always_comb begin
      ev_invalid = 1'b0;
      ev_reject = 1'b0;
      start_args = 1'b0;
      new_kind = SDC_K_WRITE;
      go_read = 1'b0;
      go_step = 1'b0;
      go_write = 1'b0;
      go_run = 1'b0;
      go_move = 1'b0;
      go_absolute_position_command = 1'b0;
      if (byte_done && state == SDC_IDLE) begin
         if (rx_byte == SDC_OP_NOP) begin
            ev_invalid = 1'b0;
         end else if (rx_byte[7:5] == SDC_OP_WRITE_HI) begin // RULE1
            // Only the speed register is read-only here
            if (reg_len(rx_byte[4:0]) == 2'd0 || rx_byte[4:0] == SDC_RA_SPEED)
               ev_invalid = 1'b1; // RULE3 RULE5
            else
               start_args = 1'b1;
         end else if (rx_byte[7:5] == SDC_OP_READ_HI) begin // RULE6
            if (reg_len(rx_byte[4:0]) == 2'd0) ev_invalid = 1'b1; // RULE9
            else go_read = 1'b1;
         end else if (rx_byte[7:1] == SDC_OP_RUN) begin // RULE10
            start_args = 1'b1;
            new_kind = SDC_K_RUN;
         end else if (rx_byte[7:1] == SDC_OP_MOVE) begin
            start_args = 1'b1;
            new_kind = SDC_K_MOVE;
         end else if (rx_byte == SDC_OP_ABSOLUTE_POSITION_COMMAND) begin
            start_args = 1'b1;
            new_kind = SDC_K_ABSOLUTE_POSITION_COMMAND;
         end else if (rx_byte[7:1] == SDC_OP_STEP) begin
            if (running_rep) ev_reject = 1'b1; // RULE17
            else go_step = 1'b1;
         end else begin
            ev_invalid = 1'b1; // RULE24
         end
      end else if (last_arg) begin
         case (kind)
            // Position load only while the motor stands still
            SDC_K_WRITE: begin
               if (addr_reg == SDC_RA_POS && running_rep) ev_reject = 1'b1; // RULE4
               else go_write = 1'b1;
            end
            SDC_K_RUN: go_run = 1'b1; // RULE13
            SDC_K_MOVE: begin
               if (running_rep) ev_reject = 1'b1; // RULE19
               else go_move = 1'b1;
            end
            SDC_K_ABSOLUTE_POSITION_COMMAND: begin
               if (!busy_n_reg) ev_reject = 1'b1; // RULE21
               else go_absolute_position_command = 1'b1;
            end
            default: ev_reject = 1'b0;
         endcase
      end
   end

   // Argument collection, MSB first [RULE2] [RULE25]
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= SDC_IDLE;
         kind <= SDC_K_WRITE;
         arg_left <= 2'd0;
         addr_reg <= 5'h00;
         arg_sh <= 16'h0000;
         last_op_reg <= 8'h00;
      end else if (byte_done) begin
         case (state)
            SDC_IDLE: begin
               if (start_args) begin
                  state <= SDC_ARGS;
                  kind <= new_kind;
                  addr_reg <= rx_byte[4:0];
                  arg_left <= (new_kind == SDC_K_WRITE) ? reg_len(rx_byte[4:0]) : SDC_ARG_BYTES;
                  last_op_reg <= rx_byte;
               end
            end
            SDC_ARGS: begin
               arg_sh <= full_arg[15:0];
               arg_left <= arg_left - 2'd1;
               if (arg_left == 2'd1) state <= SDC_IDLE;
            end
            default: state <= SDC_IDLE;
         endcase
      end
   end

   // ****************************************************
   // Response path
   // ****************************************************
   logic [15:0] resp_sh;
   logic [1:0] resp_left;

   // Snapshot taken at decode; a new read replaces any pending one [RULE7] [RULE23]
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_sh <= 8'h00;
         resp_sh <= 16'h0000;
         resp_left <= 2'd0;
      end else if (byte_done) begin
         if (go_read) begin
            tx_sh <= snap[23:16];
            resp_sh <= snap[15:0];
            resp_left <= SDC_REG_BYTES - 2'd1;
         end else if (resp_left != 2'd0) begin
            tx_sh <= resp_sh[15:8];
            resp_sh <= {resp_sh[7:0], 8'h00};
            resp_left <= resp_left - 2'd1;
         end else begin
            tx_sh <= 8'h00; // RULE22
         end
      end else if (active && sclk_fall && bit_cnt != 3'h0) begin
         tx_sh <= {tx_sh[6:0], 1'b0};
      end
   end

   // ****************************************************
   // Motion commands and mode
   // ****************************************************
   logic [19:0] spd_in, spd_clamped;

   // Top nibble of the speed is don't-care [RULE11]
   assign spd_in = full_arg[19:0];
   always_comb begin
      if (spd_in > max_spd_reg) spd_clamped = max_spd_reg; // RULE12
      else if (spd_in < min_spd_reg) spd_clamped = min_spd_reg;
      else spd_clamped = spd_in;
   end

   // Commands toward the engine, one-cycle strobes [RULE18] [RULE20]
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cmd_run <= 1'b0;
         cmd_move <= 1'b0;
         cmd_absolute_position_command <= 1'b0;
         pos_load <= 1'b0;
         cmd_arg <= 22'h000000;
      end else begin
         cmd_run <= go_run;
         cmd_move <= go_move;
         cmd_absolute_position_command <= go_absolute_position_command;
         pos_load <= go_write && addr_reg == SDC_RA_POS;
         if (go_run) cmd_arg <= {2'h0, spd_clamped};
         else if (go_move || go_absolute_position_command || go_write) cmd_arg <= full_arg[21:0];
      end
   end

   // Speed limits live here
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         max_spd_reg <= SDC_MAXSPD_RST;
         min_spd_reg <= SDC_MINSPD_RST;
      end else if (go_write) begin
         if (addr_reg == SDC_RA_MAXSPD) max_spd_reg <= full_arg[19:0];
         if (addr_reg == SDC_RA_MINSPD) min_spd_reg <= full_arg[19:0];
      end
   end

   // A new start wins over a completion arriving together
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) busy_n_reg <= 1'b1;
      else if (go_run || go_move || go_absolute_position_command) busy_n_reg <= 1'b0; // RULE13 RULE19 RULE21
      else if (motion_done) busy_n_reg <= 1'b1;
   end

   // No fault input reaches this mode on purpose [RULE16]
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sck_mode_reg <= 1'b0;
         dir_reg <= 1'b0;
      end else if (go_step) begin
         sck_mode_reg <= 1'b1; // RULE14 RULE15
         dir_reg <= rx_byte[0];
      end else if (go_run || go_move || go_absolute_position_command) begin
         sck_mode_reg <= 1'b0; // RULE15
         dir_reg <= last_op_reg[0];
      end
   end

   assign busy_n = busy_n_reg;
   assign cmd_dir = dir_reg;
   assign step_clock_mode_flag = sck_mode_reg;

   // Sticky flags; a new event beats a clear in the same cycle
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         invalid_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         if (ev_invalid) invalid_reg <= 1'b1;
         else if (apb_wr && paddr == SDC_CLR_OFS && pwdata[SDC_ST_INVALID]) invalid_reg <= 1'b0;
         if (ev_reject) reject_reg <= 1'b1;
         else if (apb_wr && paddr == SDC_CLR_OFS && pwdata[SDC_ST_REJECT]) reject_reg <= 1'b0;
      end
   end

   // Read data latched in the setup phase, stable through access
   always_comb begin
      rd_next = 32'h00000000;
      case (paddr)
         SDC_CTRL_OFS: rd_next[SDC_CTRL_EN] = ctrl_en_reg;
         SDC_STAT_OFS: begin
            rd_next[SDC_ST_INVALID] = invalid_reg;
            rd_next[SDC_ST_REJECT] = reject_reg;
            rd_next[SDC_ST_SCKMODE] = sck_mode_reg;
            rd_next[SDC_ST_BUSYN] = busy_n_reg;
            rd_next[SDC_ST_DIR] = dir_reg;
            rd_next[SDC_ST_RUNNING] = running_rep;
         end
         SDC_OPC_OFS: rd_next[7:0] = last_op_reg;
         default: rd_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) prdata <= 32'h00000000;
      else if (psel && !penable) prdata <= rd_next;
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_op_done(logic [7:0] op);
      byte_done && state == SDC_IDLE && rx_byte == op;
   endsequence

   a_bad_opcode: assert property (s_op_done(8'hff) |=> invalid_reg) // RULE24
      else $error("unknown opcode did not raise invalid flag");
   a_ro_write: assert property (s_op_done(8'h04) |=> invalid_reg && state == SDC_IDLE) // RULE3
      else $error("write to read-only register not refused");
   a_run_busy: assert property (go_run |=> !busy_n && cmd_run ##1 !cmd_run) // RULE13
      else $error("constant speed did not drive busy low");
   a_run_clamp: assert property (cmd_run && min_spd_reg <= max_spd_reg |->
         cmd_arg[19:0] <= max_spd_reg && cmd_arg[19:0] >= min_spd_reg) // RULE12
      else $error("speed outside limits");
   a_step_enter: assert property (go_step |=> step_clock_mode_flag &&
         cmd_dir == $past(rx_byte[0]) && (busy_n || !$past(busy_n))) // RULE14
      else $error("step-clock mode entry wrong");
   a_step_refuse: assert property (byte_done && state == SDC_IDLE &&
         rx_byte[7:1] == SDC_OP_STEP && running_rep |=> reject_reg && !step_clock_mode_flag) // RULE17
      else $error("step command not refused while running");
   a_mode_exit: assert property (go_run || go_move || go_absolute_position_command |=> !step_clock_mode_flag) // RULE15
      else $error("motion command did not end step-clock mode");
   a_absolute_position_command_refuse: assert property (last_arg && kind == SDC_K_ABSOLUTE_POSITION_COMMAND && !busy_n_reg |=>
         reject_reg && !cmd_absolute_position_command) // RULE21
      else $error("absolute position accepted while busy");
   a_move_refuse: assert property (last_arg && kind == SDC_K_MOVE && running_rep |=>
         reject_reg && !cmd_move) // RULE19
      else $error("relative step accepted while running");
   a_read_snap: assert property (go_read |=> tx_sh == $past(snap[23:16]) &&
         resp_left == 2'd2) // RULE7
      else $error("read response not loaded from snapshot");
   a_zero_reply: assert property (byte_done && !go_read && resp_left == 2'd0 |=>
         tx_sh == 8'h00) // RULE22
      else $error("idle reply byte not zero");

endmodule
`default_nettype wire

// ### sdc_host.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Host serial master
// ****
module sdc_host (
   // Clock
   input wire logic mclk,
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   // Idle link: clock high, select high
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // One byte per frame, MSB first; data line flips on release so no stale bit passes
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         repeat (8) @(posedge mclk);
         sclk <= 1'b0;
         mosi <= tx[i];
         repeat (8) @(posedge mclk);
         sclk <= 1'b1;
         rx[i] = miso;
      end
      repeat (8) @(posedge mclk);
      cs_n <= 1'b1;
      mosi <= ~tx[0];
      repeat (8) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// ### sdc_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
// ****
// Decoder bench
// ****
module sdc_decoder_bench
   import sdc_pkg::*;
;
   logic mclk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic sclk, cs_n, mosi, miso, miso_oe, miso_pin, running, mdone;
   logic cmd_run, cmd_move, cmd_absolute_position_command, pos_load, cmd_dir, sck_mode, busy_n;
   logic [7:0] paddr, rx;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] cur_speed;
   logic [21:0] cur_pos, cmd_arg, seen_arg;
   logic [3:0] seen;
   int mismatches, check_count, cycles;

   sdc_decoder DUT (.mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
      .spi_miso_oe(miso_oe), .motor_running(running), .motion_done(mdone),
      .cur_speed(cur_speed), .cur_pos(cur_pos), .cmd_run(cmd_run), .cmd_move(cmd_move),
      .cmd_absolute_position_command(cmd_absolute_position_command), .pos_load(pos_load), .cmd_dir(cmd_dir), .cmd_arg(cmd_arg),
      .step_clock_mode_flag(sck_mode), .busy_n(busy_n));
   sdc_host HOST (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_pin));
   // Undriven line shows the inverse, so a missing enable is caught
   assign miso_pin = miso_oe ? miso : ~miso;

   // System clock
   always #5 mclk = ~mclk;
   // Hang guard; pulses last one cycle, so they are caught here
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
      if (cmd_run | cmd_move | cmd_absolute_position_command | pos_load) begin
         seen <= seen | {cmd_run, cmd_move, cmd_absolute_position_command, pos_load};
         seen_arg <= cmd_arg;
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Only the hang guard ends a stuck access
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic stat(input logic [5:0] e);
      apb(1'b0, SDC_STAT_OFS, 32'h0);
      `CHK(rd[5:0], e)
   endtask
   task automatic clr;
      apb(1'b1, SDC_CLR_OFS, 32'h3);
   endtask
   task automatic cmd4(input logic [7:0] op, input logic [23:0] arg);
      seen = 4'h0;
      HOST.xfer(op, rx);
      for (int i = 2; i >= 0; i--) HOST.xfer(arg[8*i +: 8], rx);
   endtask
   task automatic getreg(input logic [7:0] op, output logic [23:0] v);
      HOST.xfer(op, rx);
      for (int i = 2; i >= 0; i--) begin
         HOST.xfer(8'h00, rx);
         v[8*i +: 8] = rx;
      end
   endtask
   task automatic pulse_done;
      mdone <= 1'b1;
      @(posedge mclk);
      mdone <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic t_reset;
      `CHK({sck_mode, busy_n, cmd_dir, cmd_arg}, {3'b010, 22'h0})
      apb(1'b0, SDC_CTRL_OFS, 32'h0);
      `CHK(rd[0], SDC_CTRL_EN_RST)
      apb(1'b0, 8'h10, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      stat(6'h08);
      $display("test reset done");
   endtask
   task automatic t_bad;
      logic [7:0] ops [4] = '{8'hf8, 8'h04, 8'h1f, 8'h3f};
      foreach (ops[i]) begin
         HOST.xfer(ops[i], rx);
         `CHK(rx, 8'h00)
         stat(6'h09);
         clr();
      end
      // Link off: bytes must be ignored
      apb(1'b1, SDC_CTRL_OFS, 32'h0);
      HOST.xfer(8'hf8, rx);
      `CHK(rx, 8'hff)
      stat(6'h08);
      apb(1'b1, SDC_CTRL_OFS, 32'h1);
      $display("test bad opcodes done");
   endtask
   task automatic t_reg;
      logic [7:0] ops [7] = '{8'h27, 8'h00, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] exp [7] = '{8'h00, 8'h08, 8'ha5, 8'h09, 8'hab, 8'hcd, 8'h00};
      logic [23:0] v;
      cmd4(8'h08, 24'h001234);
      cmd4(8'h07, 24'h08a5c3);
      getreg(8'h28, v);
      `CHK(v, 24'h001234)
      // Second read cuts the first; live speed changes after decode
      foreach (ops[i]) begin
         HOST.xfer(ops[i], rx);
         `CHK(rx, exp[i])
         if (i == 2) cur_speed <= 20'h11111;
      end
      $display("test registers done");
   endtask
   task automatic t_run;
      cmd4(8'h51, 24'hf9ffff);
      `CHK({seen, seen_arg, cmd_dir, busy_n}, {4'h8, 22'h08a5c3, 2'b10})
      cmd4(8'h50, 24'h000010);
      `CHK({seen, seen_arg, cmd_dir, busy_n}, {4'h8, 22'h001234, 2'b00})
      pulse_done();
      `CHK(busy_n, 1'b1)
      $display("test run done");
   endtask
   task automatic t_step;
      logic [23:0] v;
      running <= 1'b1;
      HOST.xfer(8'h01, rx);
      HOST.xfer(8'h00, rx);
      HOST.xfer(8'h01, rx);
      stat(6'h28);
      HOST.xfer(8'h00, rx);
      stat(6'h2a);
      clr();
      HOST.xfer(8'h59, rx);
      stat(6'h2a);
      clr();
      running <= 1'b0;
      HOST.xfer(8'h59, rx);
      running <= 1'b1;
      stat(6'h1c);
      HOST.xfer(8'h58, rx);
      stat(6'h0c);
      getreg(8'h28, v);
      `CHK(v, 24'h001234)
      running <= 1'b0;
      cmd4(8'h01, 24'h2abcde);
      `CHK({seen, seen_arg}, {4'h1, 22'h2abcde})
      cur_pos <= 22'h2abcde;
      getreg(8'h21, v);
      `CHK(v, 24'h2abcde)
      cmd4(8'h41, 24'hc00040);
      `CHK({seen, seen_arg, cmd_dir, sck_mode, busy_n}, {4'h4, 22'h40, 3'b100})
      running <= 1'b1;
      cmd4(8'h41, 24'h000040);
      stat(6'h32);
      clr();
      running <= 1'b0;
      cmd4(8'h60, 24'h000040);
      stat(6'h12);
      clr();
      pulse_done();
      cmd4(8'h60, 24'h3abcde);
      `CHK({seen, seen_arg, cmd_dir, busy_n}, {4'h2, 22'h3abcde, 2'b00})
      apb(1'b0, SDC_OPC_OFS, 32'h0);
      `CHK(rd[7:0], SDC_OP_ABSOLUTE_POSITION_COMMAND)
      pulse_done();
      $display("test motion done");
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {mclk, reset, psel, penable, pwrite, running, mdone} = 7'b0100000;
      {paddr, pwdata, cur_pos, seen, seen_arg} = '0;
      cur_speed = 20'h9abcd;
      mismatches = 0;
      check_count = 0;
      cycles = 0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      t_reset();
      t_bad();
      t_reg();
      t_run();
      t_step();
      complete_run();
   end
endmodule
`default_nettype wire
